// *** inc/lvdsf_consts.svh ***
`ifndef LVDSF_CONSTS_SVH
`define LVDSF_CONSTS_SVH

// fifo geometry: two channels, 16 bits, eight entries
`define LVDSF_DATA_W        16
`define LVDSF_DEPTH         8
`define LVDSF_PTR_W         3

// pointer reset value and read wrap index
`define LVDSF_PTR_RST       3'h0
`define LVDSF_PTR_LAST      3'h7

// level warning thresholds (close to empty / close to overflow)
`define LVDSF_LVL_LOW       3'h1
`define LVDSF_LVL_HIGH      3'h7

// index of the last bus unit of a sample in each narrow mode
`define LVDSF_UNITS_BYTE    2'h1
`define LVDSF_UNITS_NIBBLE  2'h3

// strobe edges with frame high that make a pointer-reset strobe
`define LVDSF_FRST_WORD     4'h2
`define LVDSF_FRST_BYTE     4'h4
`define LVDSF_FRST_NIBBLE   4'h8

`endif

// *** inc/lvdsf_pkg.sv ***
package lvdsf_pkg;

    // input bus width selection
    typedef enum logic [1:0] {
        LVDSF_WORD   = 2'b00,
        LVDSF_BYTE   = 2'b01,
        LVDSF_NIBBLE = 2'b10
    } lvdsf_mode_e;

    // sample word carried through the fifo
    typedef logic [15:0] lvdsf_word_t;

endpackage : lvdsf_pkg

// *** hdl/lvdsf_rate_div.sv ***
`timescale 1ns/1ps
`include "lvdsf_consts.svh"

// data-rate tick: converter clock divided by the interpolation ratio
module lvdsf_rate_div
    import lvdsf_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       clkEn,
    input  wire logic [1:0] interpRatioCode,  // 0..3 selects 1x, 2x, 4x, 8x
    output logic            rdTick            // one pulse per data-rate period
);

    logic [2:0] divCnt_q;      // cycles within one data period
    logic [3:0] divLimit;      // ratio minus one
    logic       rdTick_q;      // registered tick

    // ratio is a power of two, so a shift gives it
    assign divLimit = 4'(4'h1 << interpRatioCode) - 4'h1;

    // free-running divider; wraps at the limit and flags the wrap
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_q <= 3'h0;
            rdTick_q <= 1'b0;
        end else if (clkEn) begin
            if (divCnt_q >= divLimit[2:0]) begin
                divCnt_q <= 3'h0;
                rdTick_q <= 1'b1;
            end else begin
                divCnt_q <= divCnt_q + 3'h1;
                rdTick_q <= 1'b0;
            end
        end
    end

    assign rdTick = rdTick_q;

endmodule : lvdsf_rate_div

// *** hdl/lvdsf_capture.sv ***
`timescale 1ns/1ps
`include "lvdsf_consts.svh"

// ddr capture and sample formatting; write side of the fifo
module lvdsf_capture
    import lvdsf_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic [15:0] laneData,       // lane_bit15..lane_bit0
    input  wire logic        dataStrobeIn,   // reference strobe
    input  wire logic        frameSelectPos, // channel frame / reset strobe
    input  lvdsf_mode_e      busMode,
    output logic             wrValid,        // one-cycle pulse, i/q pair ready
    output logic [15:0]      wrI,
    output logic [15:0]      wrQ,
    output logic             frameReset      // one-cycle pulse
);

    // byte mode lanes, msb first
    function automatic logic [7:0] byteLanes(input logic [15:0] d);
        byteLanes = {d[14], d[12], d[10], d[8], d[7], d[5], d[3], d[1]};
    endfunction : byteLanes

    // nibble mode lanes, msb first
    function automatic logic [3:0] nibLanes(input logic [15:0] d);
        nibLanes = {d[10], d[8], d[7], d[5]};
    endfunction : nibLanes

    logic [15:0] data_q;       // bus sampled with the strobe
    logic        strb_q;       // strobe level
    logic        strbPrev_q;   // strobe level one cycle earlier
    logic        frame_q;      // frame level
    logic        frameLast_q;  // frame at previous strobe edge
    logic [1:0]  unitCnt_q;    // unit index within a sample
    logic [15:0] acc_q;        // sample under assembly
    logic [15:0] iHold_q;      // i sample waiting for its q partner
    logic [3:0]  highCnt_q;    // edges seen with frame high
    logic        wrValid_q;
    logic [15:0] wrI_q;
    logic [15:0] wrQ_q;
    logic        frameReset_q;

    logic        strbEdge;     // any strobe edge, rising or falling
    logic        unitStart;    // this edge opens a new sample
    logic [1:0]  unitIdx;
    logic [1:0]  unitLast;
    logic [15:0] accNext;
    logic [3:0]  frstLimit;

    // both strobe edges clock data in: ddr sampling
    assign strbEdge = (strb_q != strbPrev_q);

    // per-mode framing figures
    always_comb begin
        unitLast  = (busMode == LVDSF_BYTE) ? `LVDSF_UNITS_BYTE : `LVDSF_UNITS_NIBBLE;
        frstLimit = `LVDSF_FRST_NIBBLE;
        accNext   = {acc_q[11:0], nibLanes(data_q)};
        unitStart = (frame_q != frameLast_q);
        case (busMode)
            LVDSF_WORD: begin
                frstLimit = `LVDSF_FRST_WORD;
            end
            LVDSF_BYTE: begin
                frstLimit = `LVDSF_FRST_BYTE;
                accNext   = {acc_q[7:0], byteLanes(data_q)};
                unitStart = strb_q;  // upper byte always on strobe high
            end
            default: begin
                frstLimit = `LVDSF_FRST_NIBBLE;
            end
        endcase
        unitIdx = unitStart ? 2'h0 : unitCnt_q + 2'h1;
    end

    // input sampling; pins are synchronous to core_clk
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_q     <= 16'h0000;
            strb_q     <= 1'b0;
            strbPrev_q <= 1'b0;
            frame_q    <= 1'b0;
        end else if (clkEn) begin
            data_q     <= laneData;
            strb_q     <= dataStrobeIn;
            strbPrev_q <= strb_q;
            frame_q    <= frameSelectPos;
        end
    end

    // sample assembly and channel steering
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frameLast_q <= 1'b0;
            unitCnt_q   <= 2'h0;
            acc_q       <= 16'h0000;
            iHold_q     <= 16'h0000;
            wrValid_q   <= 1'b0;
            wrI_q       <= 16'h0000;
            wrQ_q       <= 16'h0000;
        end else if (clkEn) begin
            wrValid_q <= 1'b0;
            if (strbEdge) begin
                frameLast_q <= frame_q;
                if (busMode == LVDSF_WORD) begin
                    // strobe high carries i, strobe low carries q
                    if (strb_q) begin
                        iHold_q <= data_q;
                    end else begin
                        wrI_q     <= iHold_q;
                        wrQ_q     <= data_q;
                        wrValid_q <= 1'b1;
                    end
                end else begin
                    unitCnt_q <= unitIdx;
                    acc_q     <= accNext;
                    // a sample completes on its last unit; frame picks the channel
                    if (unitIdx == unitLast) begin
                        if (frame_q) begin
                            iHold_q <= accNext;
                        end else begin
                            wrI_q     <= iHold_q;
                            wrQ_q     <= accNext;
                            wrValid_q <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // frame held high for a whole i+q load becomes a reset strobe;
    // ordinary framing only covers the i half, so it never reaches the limit
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            highCnt_q    <= 4'h0;
            frameReset_q <= 1'b0;
        end else if (clkEn) begin
            frameReset_q <= 1'b0;
            if (strbEdge) begin
                if (!frame_q) begin
                    highCnt_q <= 4'h0;
                end else if (highCnt_q < frstLimit) begin
                    highCnt_q <= highCnt_q + 4'h1;
                    frameReset_q <= (highCnt_q + 4'h1 == frstLimit);
                end
            end
        end
    end

    assign wrValid    = wrValid_q;
    assign wrI        = wrI_q;
    assign wrQ        = wrQ_q;
    assign frameReset = frameReset_q;

endmodule : lvdsf_capture

// *** hdl/lvdsf_port_fifo.sv ***
`timescale 1ns/1ps
`include "lvdsf_consts.svh"

// Behaviour
// - word, byte and nibble bus widths
// - fixed lane subsets for byte and nibble
// - sample on both strobe edges
// - word mode: strobe high i, low q
// - byte mode: upper byte high, lower low
// - frame high steers to i, low q
// - two-channel 16-bit eight-entry fifo
// - write at write pointer, then advance
// - read at read pointer, then advance
// - pointers advance at the data rate
// - pointers must never coincide; here they can, and it is only flagged on ptrCollide
// - keep pointer difference near four
// - pointer init by command or frame
// - relative reset sets depth from read pointer
// - absolute reset forces fixed write pointer
// - command-requested reset is always relative
// - frame reset relative unless fifo-rate sync
// - fifo-rate sync: frame reset is absolute
// - reset strobe spans one full i+q load
// - sync mode bit: one data-rate, zero fifo-rate
// - relative: load start level at read wrap
// - absolute: load phase offset after strobe
module lvdsf_port_fifo
    import lvdsf_pkg::*;
(
    input  wire logic        core_clk,        // converter clock
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic [15:0] laneData,
    input  wire logic        dataStrobeIn,
    input  wire logic        frameSelectPos,
    input  lvdsf_mode_e      busMode,
    input  wire logic [1:0]  interpRatioCode,
    input  wire logic        syncEnable,      // synchronisation on
    input  wire logic        syncDataRate,    // 1 data-rate, 0 fifo-rate
    input  wire logic [2:0]  startLevel,      // relative reset target
    input  wire logic [2:0]  phaseOffset,     // absolute reset target
    input  wire logic        spiResetReq,     // level request from the control port
    output logic             resetAck,
    output logic             resetPending,
    output logic [15:0]      sampleI,
    output logic [15:0]      sampleQ,
    output logic             sampleValid,
    output logic [2:0]       fifoLevel,
    output logic [6:0]       fifoLevelThermo,
    output logic             levelWarn,
    output logic             ptrCollide
);

    // thermometer form of a level: 4 reads as 0001111
    function automatic logic [6:0] levelThermo(input logic [2:0] lvl);
        levelThermo = 7'(8'hff >> (4'h8 - {1'b0, lvl}));
    endfunction : levelThermo

    logic [15:0] memI [0:`LVDSF_DEPTH-1];  // i channel storage
    logic [15:0] memQ [0:`LVDSF_DEPTH-1];  // q channel storage

    logic        wrValid;       // capture has an i/q pair
    logic [15:0] wrI;
    logic [15:0] wrQ;
    logic        frameReset;    // qualified frame strobe
    logic        rdTick;        // data-rate read tick

    logic [2:0]  wrPtr_q;       // write pointer
    logic [2:0]  rdPtr_q;       // read pointer
    logic        relPending_q;  // relative reset armed
    logic        spiPend_q;     // armed reset came from the control port
    logic        spiReq_q;      // request level one cycle ago
    logic        ack_q;
    logic [15:0] sampleI_q;
    logic [15:0] sampleQ_q;
    logic        sampleValid_q;
    logic [2:0]  level_q;
    logic [6:0]  thermo_q;
    logic        warn_q;
    logic        collide_q;

    logic        absMode;       // frame strobe acts absolutely
    logic        spiRise;       // request rising edge
    logic        relSet;        // any source arms a relative reset
    logic        relLoad;       // relative reset takes effect now
    logic        absLoad;       // absolute reset takes effect now
    logic [2:0]  levelNow;

    // capture and formatting, write side
    // the strobe is sampled as a plain input on core_clk
    lvdsf_capture u_capture (
        .core_clk       (core_clk),
        .rstn           (rstn),
        .clkEn          (clkEn),
        .laneData       (laneData),
        .dataStrobeIn   (dataStrobeIn),
        .frameSelectPos (frameSelectPos),
        .busMode        (busMode),
        .wrValid        (wrValid),
        .wrI            (wrI),
        .wrQ            (wrQ),
        .frameReset     (frameReset)
    );

    // read side pace
    // the tick is registered, raised on the same edge as the divider wrap
    lvdsf_rate_div u_rate_div (
        .core_clk        (core_clk),
        .rstn            (rstn),
        .clkEn           (clkEn),
        .interpRatioCode (interpRatioCode),
        .rdTick          (rdTick)
    );

    // reset kind decode; sync disabled behaves like data-rate mode
    // only enabled fifo-rate sync makes a frame strobe absolute
    assign absMode  = syncEnable && !syncDataRate;
    assign spiRise  = spiResetReq && !spiReq_q;
    assign relSet   = spiRise || (frameReset && !absMode);
    assign absLoad  = frameReset && absMode;
    assign relLoad  = rdTick && relPending_q && (rdPtr_q == `LVDSF_PTR_LAST);
    assign levelNow = wrPtr_q - rdPtr_q;

    // storage write; no reset on the array, contents are don't-care until written
    // an enable-low cycle freezes the array as well as the pointers
    always_ff @(posedge core_clk) begin
        if (clkEn && wrValid) begin
            memI[wrPtr_q] <= wrI;
            memQ[wrPtr_q] <= wrQ;
        end
    end

    // write pointer: resets override the normal step
    // a load beats the step in one cycle; the sample still lands
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= `LVDSF_PTR_RST;
        end else if (clkEn) begin
            if (absLoad) begin
                wrPtr_q <= phaseOffset;
            end else if (relLoad) begin
                wrPtr_q <= startLevel;
            end else if (wrValid) begin
                wrPtr_q <= wrPtr_q + 3'h1;
            end
        end
    end

    // read pointer and output sample, paced by the data-rate tick
    // empty is not refused here, only reported as a collision
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdPtr_q       <= `LVDSF_PTR_RST;
            sampleI_q     <= 16'h0000;
            sampleQ_q     <= 16'h0000;
            sampleValid_q <= 1'b0;
        end else if (clkEn) begin
            sampleValid_q <= rdTick;
            if (rdTick) begin
                sampleI_q <= memI[rdPtr_q];
                sampleQ_q <= memQ[rdPtr_q];
                rdPtr_q   <= rdPtr_q + 3'h1;
            end
        end
    end

    // relative reset arming; a new request in the load cycle wins
    // the load waits for the read wrap, so depth counts from zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            relPending_q <= 1'b0;
            spiPend_q    <= 1'b0;
        end else if (clkEn) begin
            if (relSet) begin
                relPending_q <= 1'b1;
            end else if (relLoad) begin
                relPending_q <= 1'b0;
            end
            if (spiRise) begin
                spiPend_q <= 1'b1;
            end else if (relLoad) begin
                spiPend_q <= 1'b0;
            end
        end
    end

    // acknowledge: raised once the requested reset is done, dropped with the request
    // a request dropped before the load is applied but never acked
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            spiReq_q <= 1'b0;
            ack_q    <= 1'b0;
        end else if (clkEn) begin
            spiReq_q <= spiResetReq;
            if (relLoad && spiPend_q && spiResetReq) begin
                ack_q <= 1'b1;
            end else if (!spiResetReq) begin
                ack_q <= 1'b0;
            end
        end
    end

    // level status; coinciding pointers corrupt data, levels 1 and 7 are close to it
    // reported one cycle late, so read it as plus or minus one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            level_q   <= 3'h0;
            thermo_q  <= 7'h00;
            warn_q    <= 1'b0;
            collide_q <= 1'b1;
        end else if (clkEn) begin
            level_q   <= levelNow;
            thermo_q  <= levelThermo(levelNow);
            warn_q    <= (levelNow == `LVDSF_LVL_LOW) || (levelNow == `LVDSF_LVL_HIGH);
            collide_q <= (wrPtr_q == rdPtr_q);
        end
    end

    assign resetAck        = ack_q;
    assign resetPending    = relPending_q;
    assign sampleI         = sampleI_q;
    assign sampleQ         = sampleQ_q;
    assign sampleValid     = sampleValid_q;
    assign fifoLevel       = level_q;
    assign fifoLevelThermo = thermo_q;
    assign levelWarn       = warn_q;
    assign ptrCollide      = collide_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // write side: step and stored word
    // loads are excluded, they overwrite the pointer
    chk_write_step: assert property (clkEn && wrValid && !absLoad && !relLoad |=>
        wrPtr_q == 3'($past(wrPtr_q) + 3'h1)) else $error("write pointer did not step");
    chk_write_store: assert property (clkEn && wrValid |=>
        memI[$past(wrPtr_q)] == $past(wrI) && memQ[$past(wrPtr_q)] == $past(wrQ))
        else $error("sample not stored at write pointer");

    // read side: one step per data-rate tick
    chk_read_step: assert property (clkEn && rdTick |=>
        rdPtr_q == 3'($past(rdPtr_q) + 3'h1) && sampleValid) else $error("read step missing");
    chk_read_hold: assert property (clkEn && !rdTick |=>
        $stable(rdPtr_q) && !sampleValid) else $error("read pointer moved off the tick");

    // reset loads: kind and target
    // the frame threshold lives in the capture block
    chk_abs_load: assert property (clkEn && frameReset && absMode |=>
        wrPtr_q == $past(phaseOffset)) else $error("absolute reset missed phase offset");
    chk_rel_load: assert property (clkEn && relLoad |=>
        wrPtr_q == $past(startLevel) && rdPtr_q == 3'h0) else $error("relative load wrong");
    chk_spi_relative: assert property (clkEn && spiRise |=>
        relPending_q && $stable(wrPtr_q) || $past(absLoad || relLoad || wrValid))
        else $error("control port reset not relative");
    chk_frame_relative: assert property (clkEn && frameReset && !absMode |=>
        relPending_q) else $error("frame reset not armed as relative");
    chk_ack_drop: assert property (clkEn && !spiResetReq |=> !resetAck)
        else $error("acknowledge held without request");

    // status and handshake guards

    // an applied, still-held request is acknowledged
    chk_ack_raise: assert property (clkEn && relLoad && spiPend_q && spiResetReq |=>
        resetAck) else $error("no acknowledge");

    // collision flag: equal pointers, one cycle late
    chk_collide_flag: assert property (clkEn |=>
        ptrCollide == $past(wrPtr_q == rdPtr_q)) else $error("collision flag wrong");

    // warning only at levels one and seven
    chk_warn_level: assert property (clkEn |=>
        levelWarn == ($past(levelNow) == 3'h1 || $past(levelNow) == 3'h7))
        else $error("level warning wrong");

    // thermometer: one bit per unit of level
    chk_thermo_form: assert property (clkEn |=>
        fifoLevelThermo == 7'((8'h01 << fifoLevel) - 8'h01)) else $error("thermometer wrong");

    // reported level is the pointer difference
    chk_level_value: assert property (clkEn |=>
        fifoLevel == 3'($past(wrPtr_q) - $past(rdPtr_q))) else $error("level wrong");

    // an absolute load arms nothing
    chk_abs_no_arm: assert property (clkEn && absLoad && !relPending_q && !spiRise
        |=> !relPending_q) else $error("absolute reset armed relative");

    // a relative load disarms unless a new request comes
    chk_pend_clear: assert property (clkEn && relLoad && !relSet |=>
        !relPending_q) else $error("pending not cleared");

    // scenarios worth seeing
    cov_abs_reset: cover property (clkEn && absLoad);
    cov_rel_reset: cover property (clkEn && relLoad ##1 clkEn && wrValid);
    cov_collide:   cover property (clkEn && wrValid && wrPtr_q == rdPtr_q);
    cov_spi_ack:   cover property (clkEn && relLoad && spiPend_q);
    cov_frame_rel: cover property (clkEn && frameReset && !absMode);

endmodule : lvdsf_port_fifo

// *** sim/lvdsf_src.sv ***
`timescale 1ns/1ps

// behavioural sample source: one bus unit per core_clk cycle
module lvdsf_src
    import lvdsf_pkg::*;
(
    input  wire logic   core_clk,
    input  lvdsf_mode_e busMode,
    output logic [15:0] laneData,
    output logic        dataStrobeIn,
    output logic        frameSelectPos
);
    int          byteLane [8] = '{1, 3, 5, 7, 8, 10, 12, 14}; // lsb first
    int          nibLane  [4] = '{5, 7, 8, 10};               // lsb first
    logic [15:0] filler   = 16'h0001;                         // changes on ignored lanes

    // frame starts low: an unused frame input is held low
    initial begin
        laneData       = 16'h0000;
        dataStrobeIn   = 1'b0;
        frameSelectPos = 1'b0;
    end

    // the strobe toggles on every unit, so each unit is one capture edge
    task automatic put(input logic fr, input logic [15:0] u);
        @(negedge core_clk);
        filler         = {filler[14:0], ~filler[15]};
        dataStrobeIn   = ~dataStrobeIn;
        frameSelectPos = fr;
        laneData       = filler;
        case (busMode)
            LVDSF_BYTE:   for (int j = 0; j < 8; j++) laneData[byteLane[j]] = u[j];
            LVDSF_NIBBLE: for (int j = 0; j < 4; j++) laneData[nibLane[j]] = u[j];
            default:      laneData = u;
        endcase
    endtask : put

    // one i/q pair, msb unit first; i on frame high in byte and nibble modes, q on frame low
    task automatic send(input logic [15:0] i, input logic [15:0] q);
        int units;
        units = (busMode == LVDSF_BYTE) ? 2 : (busMode == LVDSF_NIBBLE) ? 4 : 1;
        // every nibble is sent, also the last one
        for (int k = units - 1; k >= 0; k--) put(busMode != LVDSF_WORD, 16'(i >> (k * 16 / units)));
        for (int k = units - 1; k >= 0; k--) put(1'b0, 16'(q >> (k * 16 / units)));
    endtask : send

    // frame held high for n units: a pointer-reset strobe
    task automatic frame_hold(input int n);
        for (int k = 0; k < n; k++) put(1'b1, 16'h0000);
    endtask : frame_hold
endmodule : lvdsf_src

// *** sim/lvdsf_port_fifo_bench.sv ***
`timescale 1ns/1ps

// stream tests: pointer resets by command in every width and by frame in byte mode
module lvdsf_port_fifo_bench
    import lvdsf_pkg::*;
;
    logic        core_clk;
    logic        rstn;
    logic        clkEn;                  // tied high
    lvdsf_mode_e busMode;
    logic [1:0]  interpRatioCode;
    logic        syncEnable;
    logic        syncDataRate;
    logic [2:0]  startLevel;
    logic [2:0]  phaseOffset;
    logic        spiResetReq;
    logic [15:0] laneData;
    logic        dataStrobeIn;
    logic        frameSelectPos;
    logic        resetAck;
    logic        resetPending;
    logic [15:0] sampleI;
    logic [15:0] sampleQ;
    logic        sampleValid;
    logic [2:0]  fifoLevel;
    int          badCount = 0;
    int          compares = 0;
    int          cycles   = 0;
    int          nSeen    = 0;          // reads checked in the current window
    logic        chkOn    = 1'b0;       // stream monitor armed
    logic        haveLast = 1'b0;
    logic [15:0] lastI;
    logic [15:0] seq      = 16'h1000;   // next i word; q is its complement
    logic        lvlOk;
    logic        ptrCollide;
    logic [6:0]  fifoLevelThermo;
    logic        levelWarn;

    lvdsf_port_fifo i_lvdsf_port_fifo (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
        .laneData(laneData), .dataStrobeIn(dataStrobeIn), .frameSelectPos(frameSelectPos),
        .busMode(busMode), .interpRatioCode(interpRatioCode), .syncEnable(syncEnable),
        .syncDataRate(syncDataRate), .startLevel(startLevel), .phaseOffset(phaseOffset),
        .spiResetReq(spiResetReq), .resetAck(resetAck), .resetPending(resetPending),
        .sampleI(sampleI), .sampleQ(sampleQ), .sampleValid(sampleValid),
        .fifoLevel(fifoLevel), .fifoLevelThermo(fifoLevelThermo), .levelWarn(levelWarn),
        .ptrCollide(ptrCollide));

    lvdsf_src i_lvdsf_src (.core_clk(core_clk), .busMode(busMode), .laneData(laneData),
        .dataStrobeIn(dataStrobeIn), .frameSelectPos(frameSelectPos));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard: the tests need about 1100 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            badCount++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // a read must return the next counting word, with its complement on q
    always @(negedge core_clk) begin
        if (chkOn && sampleValid === 1'b1) begin
            if (haveLast) begin
                check(sampleI, lastI + 16'h0001);
                check(sampleQ, ~sampleI);
            end
            lastI    = sampleI;
            haveLast = 1'b1;
            nSeen++;
        end
    end

    // back-to-back pairs, so writes keep pace with reads
    task automatic stream(input int n);
        for (int k = 0; k < n; k++) begin
            i_lvdsf_src.send(seq, ~seq);
            seq++;
        end
    endtask : stream

    // command-requested reset: arm, wait for the load, then drop the request
    task automatic spi_reset();
        int n;
        @(negedge core_clk);
        spiResetReq = 1'b1;
        for (n = 0; n < 4 && resetPending !== 1'b1; n++) @(negedge core_clk);
        check(16'(resetPending), 16'h0001);
        for (n = 0; n < 80 && resetAck !== 1'b1; n++) @(negedge core_clk);
        check(16'(resetAck), 16'h0001);
        check(16'(resetPending), 16'h0000);
        spiResetReq = 1'b0;
        repeat (2) @(negedge core_clk);
        check(16'(resetAck), 16'h0000);
    endtask : spi_reset

    // monitored run, then the depth must sit within one of the start level
    task automatic window(input int n);
        haveLast = 1'b0;
        nSeen    = 0;
        chkOn    = 1'b1;
        stream(n);
        chkOn    = 1'b0;
        lvlOk    = (3'(fifoLevel - startLevel + 3'h1) <= 3'h2);
        check(16'(lvlOk), 16'h0001);
        check(16'(fifoLevelThermo), 16'((16'h1 << fifoLevel) - 16'h1));
        check(16'(levelWarn), 16'h0000);
        check(16'(ptrCollide), 16'h0000);
        check(16'(resetPending), 16'h0000);
        check(16'(nSeen >= 8), 16'h0001);
    endtask : window

    initial begin
        rstn = 1'b0;
        clkEn = 1'b1;
        busMode = LVDSF_WORD;
        interpRatioCode = 2'h1;
        syncEnable = 1'b0;
        syncDataRate = 1'b1;
        startLevel = 3'h4;
        phaseOffset = 3'h6;
        spiResetReq = 1'b0;
        repeat (20) @(negedge core_clk);
        check(16'(ptrCollide), 16'h0001);   // both pointers at zero
        check(16'(sampleValid), 16'h0000);
        check(16'(fifoLevel), 16'h0000);
        rstn = 1'b1;
        // each width at its balanced rate; nibble runs under absolute sync
        for (int m = 0; m < 3; m++) begin
            busMode = lvdsf_mode_e'(m);
            interpRatioCode = 2'(m + 1);
            startLevel = 3'(3 + m);
            syncEnable = (m == 2);
            syncDataRate = (m != 2);
            fork
                stream(24);
                spi_reset();
            join
            window(16);
            $display("width test %0d done", m);
        end
        // frame strobe: relative when sync off or data-rate, absolute in fifo-rate
        busMode = LVDSF_BYTE;
        interpRatioCode = 2'h2;
        startLevel = 3'h4;
        for (int c = 0; c < 3; c++) begin
            syncEnable = (c != 0);
            syncDataRate = (c == 1);
            stream(8);
            i_lvdsf_src.frame_hold(4);
            fork
                stream(24);
                begin
                    for (int n = 0; n < 8 && resetPending !== 1'b1; n++) @(negedge core_clk);
                    check(16'(resetPending), 16'(c != 2));
                end
            join
            if (c != 2)
                window(12);
            $display("frame test %0d done", c);
        end
        end_of_test();
    end
endmodule : lvdsf_port_fifo_bench
